// ===== cbfs_pkg.sv
package cbfs_pkg;

  // Clock period of clk_in in nanoseconds (25 MHz).
  localparam int CLK_PERIOD_NS = 40;

  // Sampling window for a single-ended receiver after a differential edge.
  // This is a longest time, so it rounds down.
  localparam int OW_WINDOW_NS = 1000;
  localparam int OW_WINDOW_CYC = (OW_WINDOW_NS / CLK_PERIOD_NS) < 1 ? 1 :
                                 (OW_WINDOW_NS / CLK_PERIOD_NS);

  // Open-wire counter threshold and its width.
  localparam int OW_LIMIT = 4;
  localparam int OW_CNT_W = 3;

  // Transmit stuck-dominant timeout, least value 0.75 ms, rounded up.
  localparam int TXTO_US = 750;
  localparam int TXTO_CYC = (TXTO_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Recessive time needed to release the stuck-dominant cut, rounded up.
  localparam int TXREC_NS = 32000;
  localparam int TXREC_CYC = (TXREC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Wake-up filter time, typical value, rounded up.
  localparam int WAKE_NS = 16000;
  localparam int WAKE_CYC = (WAKE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Values after reset.
  localparam logic RX_RESET = 1'b1;
  localparam logic TERM_RESET = 1'b1;

  // Chip operating mode as seen by the transceiver.
  typedef enum logic [1:0] {
    CBFS_SBC_NORMAL  = 2'h0,
    CBFS_SBC_STANDBY = 2'h1,
    CBFS_SBC_STOP    = 2'h2,
    CBFS_SBC_SLEEP   = 2'h3
  } cbfs_sbc_mode_t;

  // Transceiver mode; code 3 is unused and treated as battery terminated.
  typedef enum logic [1:0] {
    CBFS_CAN_TXRX    = 2'h0,
    CBFS_CAN_RXONLY  = 2'h1,
    CBFS_CAN_TERMBAT = 2'h2
  } cbfs_can_mode_t;

  // Digitised comparator outputs, each high while its line reads dominant.
  typedef struct packed {
    logic diff_dom;
    logic high_dom;
    logic low_dom;
    logic wake_dom;
  } cbfs_bus_t;

  // Filtered short detectors of the analog front end.
  typedef struct packed {
    logic high_to_5v;
    logic high_to_bat;
    logic low_to_gnd;
    logic low_to_high;
    logic low_to_bat;
    logic low_to_5v;
  } cbfs_fault_t;

endpackage

// ===== cbfs_open_wire.sv
`timescale 1ns/100ps
module cbfs_open_wire #(
  parameter bit SECOND_VARIANT = 1'b1
) (
  input wire logic clk_in,
  input wire logic arst_n_in,
  input wire logic en_in,
  input wire logic diff_dom_in,
  input wire logic se_dom_in,
  output logic open_flag_out
);

  typedef enum logic [1:0] {
    OW_IDLE = 2'b01,
    OW_WIN  = 2'b10
  } cbfs_ow_state_t;

  cbfs_ow_state_t state_q, state_d;
  logic diff_q, diff_d;
  logic seen_q, seen_d;
  logic [4:0] win_q, win_d;
  logic [cbfs_pkg::OW_CNT_W-1:0] cnt_q, cnt_d;
  logic flag_q, flag_d;

  // A window opens on a differential move to dominant while receiving and no window is open, and closes after
  // the window time; the single-ended receiver must show dominant inside it.
  always_comb begin
    state_d = state_q;
    diff_d = diff_dom_in;
    seen_d = seen_q;
    win_d = win_q;
    cnt_d = cnt_q;
    flag_d = flag_q;
    unique case (state_q)
      OW_IDLE: begin
        if (en_in && diff_dom_in && !diff_q) begin
          state_d = OW_WIN;
          win_d = 5'h00;
          seen_d = se_dom_in;
        end
      end
      OW_WIN: begin
        seen_d = seen_q | se_dom_in;
        win_d = win_q + 5'h01;
        if (win_q == 5'((cbfs_pkg::OW_WINDOW_CYC - 1))) begin
          state_d = OW_IDLE;
          // Sending aborts the sample, so only received traffic counts.
          if (en_in) begin
            if (!flag_q) begin
              if (!seen_d) begin
                cnt_d = cnt_q + 3'h1;
                flag_d = (cnt_q + 3'h1) == 3'(cbfs_pkg::OW_LIMIT);
              end
            end else if (seen_d) begin
              cnt_d = cnt_q - 3'h1;
              flag_d = (cnt_q != 3'h1);
            end else if (SECOND_VARIANT && cnt_q != 3'(cbfs_pkg::OW_LIMIT)) begin
              cnt_d = cnt_q + 3'h1;
            end
          end
        end
      end
    endcase
  end

  // State registers.
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      state_q <= OW_IDLE;
      diff_q <= 1'b0;
      seen_q <= 1'b0;
      win_q <= 5'h00;
      cnt_q <= 3'h0;
      flag_q <= 1'b0;
    end else begin
      state_q <= state_d;
      diff_q <= diff_d;
      seen_q <= seen_d;
      win_q <= win_d;
      cnt_q <= cnt_d;
      flag_q <= flag_d;
    end
  end

  assign open_flag_out = flag_q;

  a_ow_flag_limit: assert property (@(posedge clk_in) disable iff (!arst_n_in)
    $rose(flag_q) |-> cnt_q == 3'(cbfs_pkg::OW_LIMIT))
    else $error("Open-wire flag rose below the count limit.");

  a_ow_hold_idle: assert property (@(posedge clk_in) disable iff (!arst_n_in)
    !en_in |=> $stable(cnt_q))
    else $error("Open-wire counter moved while not receiving.");

  a_ow_recover_zero: assert property (@(posedge clk_in) disable iff (!arst_n_in)
    $fell(flag_q) |-> cnt_q == 3'h0)
    else $error("Open-wire flag cleared with a nonzero counter.");

endmodule

// ===== cbfs_tx_timeout.sv
`timescale 1ns/100ps
module cbfs_tx_timeout #(
  parameter int TIMEOUT_CYC = cbfs_pkg::TXTO_CYC
) (
  input wire logic clk_in,
  input wire logic arst_n_in,
  input wire logic tx_dom_in,
  output logic stuck_out
);

  // The shared counter must hold the longer of the two spans, or the
  // recessive release would wrap early under a short simulation timeout.
  localparam int CW = $clog2((TIMEOUT_CYC > cbfs_pkg::TXREC_CYC ? TIMEOUT_CYC :
                              cbfs_pkg::TXREC_CYC) + 1);

  logic [CW-1:0] cnt_q, cnt_d;
  logic stuck_q, stuck_d;

  // One counter serves both directions: dominant time before the cut,
  // recessive time after it, which saves a second wide counter.
  always_comb begin
    cnt_d = cnt_q;
    stuck_d = stuck_q;
    if (!stuck_q) begin
      if (!tx_dom_in) begin
        cnt_d = '0;
      end else if (cnt_q == CW'(TIMEOUT_CYC - 1)) begin
        stuck_d = 1'b1;
        cnt_d = '0;
      end else begin
        cnt_d = cnt_q + CW'(1);
      end
    end else begin
      if (tx_dom_in) begin
        cnt_d = '0;
      end else if (cnt_q == CW'(cbfs_pkg::TXREC_CYC - 1)) begin
        stuck_d = 1'b0;
        cnt_d = '0;
      end else begin
        cnt_d = cnt_q + CW'(1);
      end
    end
  end

  // State registers.
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      cnt_q <= '0;
      stuck_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      stuck_q <= stuck_d;
    end
  end

  assign stuck_out = stuck_q;

  a_tx_rec_release: assert property (@(posedge clk_in) disable iff (!arst_n_in)
    $fell(stuck_q) |-> !$past(tx_dom_in))
    else $error("Stuck flag released without recessive transmit input.");

endmodule

// ===== cbfs_supervisor.sv
`timescale 1ns/100ps
// Overview of operation
// - Supervise both lines in transmit-receive or receive-only.
// - Undo every fault action automatically on recovery.
// - No fault: both drivers, terminations, differential receive.
// - Open wire is diagnostic only.
// - High shorts: cut high driver, termination; low receiver.
// - Low shorts: cut low driver, termination; high receiver.
// - Low to 5 V: keep low side, differential receive.
// - Sample single-ended receivers in window after edges.
// - Count mismatches; flag open wire at four.
// - Update open-wire detection only while receiving.
// - First variant: after flag, only decrement to recover.
// - Second variant: up/down, saturate at four.
// - Cut drivers when transmit stays dominant too long.
// - Expose stuck-dominant flag as register bit one.
// - Release after transmit recessive about 32 us.
// - Second variant: receive pin mirrors bus while battery terminated in normal or standby, not in sleep or stop.
// - Battery-terminated report uses the wake comparators.
// - Normal/standby wake: first variant silent, no flag.
// - Wake in sleep requests normal mode, sets flag.
// - Wake in stop pulses interrupt, sets flag.
// - Transmit input low means dominant.
// - Sleep or stop forces battery-terminated state.
module cbfs_supervisor #(
  parameter bit SECOND_VARIANT = 1'b1,
  parameter int TIMEOUT_CYC = cbfs_pkg::TXTO_CYC
) (
  input wire logic clk_in,
  input wire logic arst_n_in,
  input wire logic tx_n_in,
  input wire cbfs_pkg::cbfs_sbc_mode_t sbc_mode_in,
  input wire cbfs_pkg::cbfs_can_mode_t can_mode_in,
  input wire cbfs_pkg::cbfs_bus_t bus_in,
  input wire cbfs_pkg::cbfs_fault_t fault_in,
  input wire logic bus_wake_flag_clr_in,
  output logic rx_n_out,
  output logic drive_high_out,
  output logic drive_low_out,
  output logic high_line_termination_out,
  output logic low_line_termination_out,
  output logic low_receiver_sel_out,
  output logic high_receiver_sel_out,
  output logic battery_terminated_state_out,
  output logic open_high_flag_out,
  output logic open_low_flag_out,
  output logic [3:0] reset_control_register_out,
  output logic bus_wake_flag_out,
  output logic int_pulse_out,
  output logic normal_request_out
);

  logic tx_dom;
  logic sleepish;
  logic termbat;
  logic supervise;
  logic high_fault;
  logic low_fault;
  logic stuck;
  logic [1:0] open_flags;
  logic [1:0] se_dom;
  logic low_power;

  // The transmit pin is active low: low asks for a dominant bus.
  assign tx_dom = !tx_n_in;
  assign low_power = (sbc_mode_in == cbfs_pkg::CBFS_SBC_STOP) ||
                     (sbc_mode_in == cbfs_pkg::CBFS_SBC_SLEEP);
  assign sleepish = low_power;
  // Sleep and stop force battery termination whatever mode was selected.
  assign termbat = sleepish || (can_mode_in != cbfs_pkg::CBFS_CAN_TXRX &&
                                can_mode_in != cbfs_pkg::CBFS_CAN_RXONLY);
  assign supervise = !termbat;

  // Fault classes follow the short detectors level by level, so removing a
  // short undoes its actions on the next edge with no latch to clear.
  assign high_fault = supervise && (fault_in.high_to_5v || fault_in.high_to_bat);
  assign low_fault = supervise && (fault_in.low_to_gnd || fault_in.low_to_high ||
                                   fault_in.low_to_bat);

  // The stuck-dominant timer watches the pin itself in every mode.
  cbfs_tx_timeout #(
    .TIMEOUT_CYC(TIMEOUT_CYC)
  ) u_tx_timeout (
    .clk_in(clk_in),
    .arst_n_in(arst_n_in),
    .tx_dom_in(tx_dom),
    .stuck_out(stuck)
  );

  // One open-wire detector per line; index 0 watches the high line.
  assign se_dom = {bus_in.low_dom, bus_in.high_dom};
  generate
    for (genvar i = 0; i < 2; i++) begin : g_ow
      cbfs_open_wire #(
        .SECOND_VARIANT(SECOND_VARIANT)
      ) u_ow (
        .clk_in(clk_in),
        .arst_n_in(arst_n_in),
        .en_in(supervise && !tx_dom),
        .diff_dom_in(bus_in.diff_dom),
        .se_dom_in(se_dom[i]),
        .open_flag_out(open_flags[i])
      );
    end
  endgenerate

  // Driver, termination and receiver selection.
  logic drv_h_q, drv_h_d;
  logic drv_l_q, drv_l_d;
  logic term_h_q, term_h_d;
  logic term_l_q, term_l_d;
  logic sel_l_q, sel_l_d;
  logic sel_h_q, sel_h_d;
  logic rx_n_q, rx_n_d;
  logic termbat_q;
  logic [1:0] open_q;
  logic stuck_q;

  // Wake filter state.
  logic [8:0] wake_cnt_q, wake_cnt_d;
  logic wake_fired_q, wake_fired_d;
  logic wake_evt;
  logic wake_report;
  logic wake_flag_q, wake_flag_d;
  logic int_q, int_d;
  logic nreq_q, nreq_d;

  // The open-wire flags feed nothing in this path: an open line keeps the
  // default set-up and is only reported.
  always_comb begin
    drv_h_d = 1'b0;
    drv_l_d = 1'b0;
    term_h_d = !high_fault;
    term_l_d = !low_fault;
    sel_l_d = high_fault;
    sel_h_d = !high_fault && low_fault;
    rx_n_d = 1'b1;
    if (supervise && can_mode_in == cbfs_pkg::CBFS_CAN_TXRX && !stuck) begin
      drv_h_d = tx_dom && !high_fault;
      drv_l_d = tx_dom && !low_fault;
    end
    if (supervise) begin
      if (high_fault) begin
        rx_n_d = !bus_in.low_dom;
      end else if (low_fault) begin
        rx_n_d = !bus_in.high_dom;
      end else begin
        rx_n_d = !bus_in.diff_dom;
      end
    end else if (SECOND_VARIANT && !low_power) begin
      rx_n_d = !wake_report;
    end
  end

  // Wake filter on the wake comparators; one event per dominant period.
  // Using the wake comparators keeps the report alive through bus faults.
  assign wake_evt = termbat && bus_in.wake_dom && !wake_fired_q &&
                    wake_cnt_q == 9'(cbfs_pkg::WAKE_CYC - 1);
  assign wake_report = termbat && bus_in.wake_dom && wake_fired_q;

  always_comb begin
    wake_cnt_d = wake_cnt_q;
    wake_fired_d = wake_fired_q;
    if (!termbat || !bus_in.wake_dom) begin
      wake_cnt_d = 9'h000;
      wake_fired_d = 1'b0;
    end else if (wake_evt) begin
      wake_fired_d = 1'b1;
    end else if (!wake_fired_q) begin
      wake_cnt_d = wake_cnt_q + 9'h001;
    end
  end

  // Wake consequences per chip mode; a set in the same cycle as a clear wins.
  always_comb begin
    wake_flag_d = wake_flag_q && !bus_wake_flag_clr_in;
    int_d = 1'b0;
    nreq_d = 1'b0;
    if (wake_evt && sbc_mode_in == cbfs_pkg::CBFS_SBC_SLEEP) begin
      nreq_d = 1'b1;
      wake_flag_d = 1'b1;
    end
    if (wake_evt && sbc_mode_in == cbfs_pkg::CBFS_SBC_STOP) begin
      int_d = 1'b1;
      wake_flag_d = 1'b1;
    end
  end

  // All outputs leave from these flip-flops.
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      drv_h_q <= 1'b0;
      drv_l_q <= 1'b0;
      term_h_q <= cbfs_pkg::TERM_RESET;
      term_l_q <= cbfs_pkg::TERM_RESET;
      sel_l_q <= 1'b0;
      sel_h_q <= 1'b0;
      rx_n_q <= cbfs_pkg::RX_RESET;
      termbat_q <= 1'b0;
      open_q <= 2'h0;
      stuck_q <= 1'b0;
      wake_cnt_q <= 9'h000;
      wake_fired_q <= 1'b0;
      wake_flag_q <= 1'b0;
      int_q <= 1'b0;
      nreq_q <= 1'b0;
    end else begin
      drv_h_q <= drv_h_d;
      drv_l_q <= drv_l_d;
      term_h_q <= term_h_d;
      term_l_q <= term_l_d;
      sel_l_q <= sel_l_d;
      sel_h_q <= sel_h_d;
      rx_n_q <= rx_n_d;
      termbat_q <= termbat;
      open_q <= open_flags;
      stuck_q <= stuck;
      wake_cnt_q <= wake_cnt_d;
      wake_fired_q <= wake_fired_d;
      wake_flag_q <= wake_flag_d;
      int_q <= int_d;
      nreq_q <= nreq_d;
    end
  end

  assign rx_n_out = rx_n_q;
  assign drive_high_out = drv_h_q;
  assign drive_low_out = drv_l_q;
  assign high_line_termination_out = term_h_q;
  assign low_line_termination_out = term_l_q;
  assign low_receiver_sel_out = sel_l_q;
  assign high_receiver_sel_out = sel_h_q;
  assign battery_terminated_state_out = termbat_q;
  assign open_high_flag_out = open_q[0];
  assign open_low_flag_out = open_q[1];
  // Read view of the reset control register: stuck flag in bit 1, wake in bit 0.
  assign reset_control_register_out = {2'h0, stuck_q, wake_flag_q};
  assign bus_wake_flag_out = wake_flag_q;
  assign int_pulse_out = int_q;
  assign normal_request_out = nreq_q;

  // Named steps of the wake behaviour.
  sequence s_wake_sleep;
    wake_evt && sbc_mode_in == cbfs_pkg::CBFS_SBC_SLEEP;
  endsequence

  sequence s_wake_stop;
    wake_evt && sbc_mode_in == cbfs_pkg::CBFS_SBC_STOP;
  endsequence

  a_nofault_default: assert property (@(posedge clk_in) disable iff (!arst_n_in)
    supervise && !high_fault && !low_fault && !stuck && tx_dom &&
    can_mode_in == cbfs_pkg::CBFS_CAN_TXRX
    |=> drv_h_q && drv_l_q && term_h_q && term_l_q && rx_n_q == !$past(bus_in.diff_dom))
    else $error("Fault-free set-up not applied.");

  a_high_fault_cut: assert property (@(posedge clk_in) disable iff (!arst_n_in)
    high_fault |=> !drv_h_q && !term_h_q && rx_n_q == !$past(bus_in.low_dom))
    else $error("High-line short not handled.");

  a_low_fault_cut: assert property (@(posedge clk_in) disable iff (!arst_n_in)
    low_fault && !high_fault |=> !drv_l_q && !term_l_q && rx_n_q == !$past(bus_in.high_dom))
    else $error("Low-line short not handled.");

  a_low_5v_kept: assert property (@(posedge clk_in) disable iff (!arst_n_in)
    supervise && fault_in.low_to_5v && !high_fault && !low_fault |=> term_l_q && !sel_h_q)
    else $error("Low-line short to supply changed the low side.");

  a_stuck_cut: assert property (@(posedge clk_in) disable iff (!arst_n_in)
    stuck |=> !drv_h_q && !drv_l_q && stuck_q)
    else $error("Drivers active while transmit is stuck.");

  a_sleep_wake: assert property (@(posedge clk_in) disable iff (!arst_n_in)
    s_wake_sleep |=> nreq_q && wake_flag_q ##1 !nreq_q)
    else $error("Sleep wake did not request normal mode.");

  a_stop_wake: assert property (@(posedge clk_in) disable iff (!arst_n_in)
    s_wake_stop |=> int_q && wake_flag_q)
    else $error("Stop wake did not pulse the interrupt.");

  a_termbat_forced: assert property (@(posedge clk_in) disable iff (!arst_n_in)
    low_power |=> termbat_q && !drv_h_q && !drv_l_q)
    else $error("Low-power mode left the interface active.");

  a_quiet_wake: assert property (@(posedge clk_in) disable iff (!arst_n_in)
    wake_evt && !low_power |=> !wake_flag_q || $past(wake_flag_q))
    else $error("Wake in normal or standby set the wake flag.");

endmodule

// ===== cbfs_bus_model.sv
`timescale 1ns/100ps
// Far side of the transceiver: the other bus nodes and the wiring, as the comparators see them.
module cbfs_bus_model (
  input wire logic other_dom_in,
  input wire logic tx_n_in,
  input wire logic drv_in,
  input wire logic open_high_in,
  input wire logic open_low_in,
  input wire logic short_high_in,
  input wire logic short_low_in,
  output cbfs_pkg::cbfs_bus_t bus_out
);
  logic dom;

  // Our own node reaches the wires only while one of its drivers is on.
  assign dom = other_dom_in | (~tx_n_in & drv_in);

  // A short pins its line at the dominant reading, so the differential view is spoiled too.
  // An open wire never toggles, which is what the open-wire counter has to notice.
  always_comb begin
    bus_out.diff_dom = dom | short_high_in | short_low_in;
    bus_out.high_dom = (dom & ~open_high_in) | short_high_in;
    bus_out.low_dom = (dom & ~open_low_in) | short_low_in;
    bus_out.wake_dom = other_dom_in;
  end
endmodule

// ===== cbfs_supervisor_tb.sv
`timescale 1ns/100ps
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin mismatches++; \
  $display("[ERR] %0t got %h expected %h", $time, g, e); end end
module cbfs_supervisor_tb;
  typedef struct packed {
    logic [14:0] mask;
    logic [14:0] val;
  } cbfs_note_t;
  // A short timeout keeps the stuck-dominant scenario brief.
  localparam int TO_CYC = 50;
  logic clk_in = 1'b0;
  logic arst_n_in = 1'b0;
  logic tx_n_in = 1'b1;
  cbfs_pkg::cbfs_sbc_mode_t sbc_mode_in = cbfs_pkg::CBFS_SBC_NORMAL;
  cbfs_pkg::cbfs_can_mode_t can_mode_in = cbfs_pkg::CBFS_CAN_TXRX;
  cbfs_pkg::cbfs_bus_t bus_in;
  cbfs_pkg::cbfs_fault_t fault_in = '0;
  logic clr_in = 1'b0;
  logic other_dom = 1'b0;
  logic open_h = 1'b0;
  logic open_l = 1'b0;
  logic short_h = 1'b0;
  logic short_l = 1'b0;
  logic rx_n, dh, dl, ht, lt, ls, hs, tb, oh, ol, wf, ip, nr;
  logic [3:0] reset_control_register;
  logic [14:0] obs;
  logic [15:0] rnd = 16'haeb1;
  int checks = 0;
  int mismatches = 0;
  int n_int = 0;
  int n_nreq = 0;
  cbfs_note_t notes[$];

  // Observed outputs in one word, so an expectation is a mask and a value.
  assign obs = {rx_n, dh, dl, ht, lt, ls, hs, tb, oh, ol, reset_control_register, wf};

  // Free-running bench clock.
  always #20 clk_in = ~clk_in;

  cbfs_bus_model u_cbfs_bus_model (
    .other_dom_in(other_dom),
    .tx_n_in(tx_n_in),
    .drv_in(dh | dl),
    .open_high_in(open_h),
    .open_low_in(open_l),
    .short_high_in(short_h),
    .short_low_in(short_l),
    .bus_out(bus_in)
  );

  cbfs_supervisor #(.SECOND_VARIANT(1'b1), .TIMEOUT_CYC(TO_CYC)) u_cbfs_supervisor (
    .clk_in(clk_in),
    .arst_n_in(arst_n_in),
    .tx_n_in(tx_n_in),
    .sbc_mode_in(sbc_mode_in),
    .can_mode_in(can_mode_in),
    .bus_in(bus_in),
    .fault_in(fault_in),
    .bus_wake_flag_clr_in(clr_in),
    .rx_n_out(rx_n),
    .drive_high_out(dh),
    .drive_low_out(dl),
    .high_line_termination_out(ht),
    .low_line_termination_out(lt),
    .low_receiver_sel_out(ls),
    .high_receiver_sel_out(hs),
    .battery_terminated_state_out(tb),
    .open_high_flag_out(oh),
    .open_low_flag_out(ol),
    .reset_control_register_out(reset_control_register),
    .bus_wake_flag_out(wf),
    .int_pulse_out(ip),
    .normal_request_out(nr)
  );

  // Judged a little after the edge, so registered outputs have settled and pulses are seen once.
  always @(posedge clk_in) begin
    #5;
    if (ip === 1'b1) n_int++;
    if (nr === 1'b1) n_nreq++;
    while (notes.size() > 0) begin
      cbfs_note_t nt;
      nt = notes.pop_front();
      `CHK(obs & nt.mask, nt.val)
    end
  end

  task automatic cyc(input int n);
    repeat (n) @(negedge clk_in);
  endtask

  // Inputs stay put for the cycle in which the note is judged.
  task automatic chk(input logic [14:0] m, input logic [14:0] v);
    notes.push_back('{m, v});
    cyc(1);
  endtask

  function automatic int rand8();
    rnd = {rnd[14:0], rnd[15] ^ rnd[13] ^ rnd[12] ^ rnd[10]};
    return int'(rnd[2:0]);
  endfunction

  // One dominant period from us or from another node; always shorter than the timeout.
  task automatic pulses(input int n, input logic own);
    repeat (n) begin
      if (own) begin
        tx_n_in = 1'b0;
      end else begin
        other_dom = 1'b1;
      end
      cyc(30 + rand8());
      tx_n_in = 1'b1;
      other_dom = 1'b0;
      cyc(30 + rand8());
    end
  endtask

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // A hang is cut short here and counted as a mismatch.
  initial begin
    repeat (60000) @(posedge clk_in);
    mismatches++;
    give_verdict();
  end

  // Main sequence: reset, fault table, open wire, stuck transmit, wake handling.
  initial begin
    cyc(7);
    chk(15'h7fff, 15'h4c00);
    arst_n_in = 1'b1;
    cyc(4);
    chk(15'h7fff, 15'h4c00);
    // Drivers show on the outputs only while our own node sends dominant.
    tx_n_in = 1'b0;
    cyc(3);
    chk(15'h7f80, 15'h3c00);
    tx_n_in = 1'b1;
    for (int i = 0; i < 6; i++) begin
      fault_in = cbfs_pkg::cbfs_fault_t'(6'h20 >> i);
      short_h = (i < 2);
      short_l = (i >= 2 && i < 5);
      // Sending keeps the open-wire windows shut and shows which driver is cut.
      tx_n_in = 1'b0;
      cyc(3);
      chk(15'h7f80, i < 2 ? 15'h1600 : i < 5 ? 15'h2900 : 15'h3c00);
      fault_in = '0;
      short_h = 1'b0;
      short_l = 1'b0;
      tx_n_in = 1'b1;
      cyc(3);
      chk(15'h7f80, 15'h4c00);
    end
    can_mode_in = cbfs_pkg::CBFS_CAN_RXONLY;
    fault_in.high_to_bat = 1'b1;
    other_dom = 1'b1;
    cyc(3);
    chk(15'h7a00, 15'h0200);
    fault_in = '0;
    other_dom = 1'b0;
    can_mode_in = cbfs_pkg::CBFS_CAN_TXRX;
    cyc(3);
    // Our own frames must not count, even with the low wire open.
    open_l = 1'b1;
    pulses(4, 1'b1);
    chk(15'h0020, 15'h0000);
    pulses(3, 1'b0);
    chk(15'h0020, 15'h0000);
    pulses(1, 1'b0);
    chk(15'h7fe0, 15'h4c20);
    // A miss in mid-recovery pushes the count back up by one.
    open_l = 1'b0;
    pulses(3, 1'b0);
    open_l = 1'b1;
    pulses(1, 1'b0);
    open_l = 1'b0;
    pulses(1, 1'b0);
    chk(15'h0020, 15'h0020);
    pulses(1, 1'b0);
    chk(15'h0020, 15'h0000);
    open_h = 1'b1;
    pulses(4, 1'b0);
    chk(15'h0040, 15'h0040);
    open_h = 1'b0;
    pulses(4, 1'b0);
    chk(15'h0040, 15'h0000);
    tx_n_in = 1'b0;
    cyc(TO_CYC - 5);
    chk(15'h301e, 15'h3000);
    cyc(8);
    chk(15'h301e, 15'h0004);
    tx_n_in = 1'b1;
    cyc(780);
    chk(15'h301e, 15'h0004);
    // Ask for dominant again so the re-enabled drivers become visible.
    cyc(28);
    tx_n_in = 1'b0;
    cyc(2);
    chk(15'h301e, 15'h3000);
    tx_n_in = 1'b1;
    // A fault stays present: the wake comparators must still report.
    can_mode_in = cbfs_pkg::CBFS_CAN_TERMBAT;
    fault_in.low_to_gnd = 1'b1;
    for (int m = 0; m < 2; m++) begin
      sbc_mode_in = cbfs_pkg::cbfs_sbc_mode_t'(2'(m));
      other_dom = 1'b1;
      cyc(390);
      chk(15'h4081, 15'h4080);
      cyc(25);
      chk(15'h4081, 15'h0080);
      cyc(80);
      other_dom = 1'b0;
      cyc(3);
      chk(15'h4000, 15'h4000);
    end
    fault_in = '0;
    can_mode_in = cbfs_pkg::CBFS_CAN_TXRX;
    for (int m = 2; m < 4; m++) begin
      sbc_mode_in = cbfs_pkg::cbfs_sbc_mode_t'(2'(m));
      cyc(3);
      chk(15'h309f, 15'h0080);
      other_dom = 1'b1;
      cyc(450);
      other_dom = 1'b0;
      cyc(3);
      chk(15'h309f, 15'h0083);
      `CHK(n_int, 1)
      `CHK(n_nreq, m - 2)
      clr_in = 1'b1;
      cyc(1);
      clr_in = 1'b0;
      cyc(3);
      chk(15'h0003, 15'h0000);
    end
    cyc(2);
    give_verdict();
  end
endmodule
